// ### design/matrix_scan_pkg.sv
// constants and carrier types for the matrix scan and glyph pointer block
package matrix_scan_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_NULL        = 8'h00;
  localparam logic [7:0] IDX_BRIGHT_LOW  = 8'h01;
  localparam logic [7:0] IDX_BRIGHT_HIGH = 8'h02;
  localparam logic [7:0] IDX_SCAN_LIMIT  = 8'h03;
  localparam logic [7:0] IDX_CONFIG      = 8'h04;
  localparam logic [7:0] IDX_GLYPH       = 8'h05;
  // config and scan limit register field positions
  localparam int CFG_SYNC_BIT  = 4;
  localparam int CFG_PHASE_BIT = 7;
  localparam int SCAN_LIMIT_BIT = 0;
  // reset values
  localparam logic [7:0] BRIGHT_RESET     = 8'h00;
  localparam logic       SCAN_LIMIT_RESET = 1'b0;
  localparam logic       PHASE_RESET      = 1'b1;
  // glyph pointer range and layout
  localparam logic [7:0] PTR_FIRST   = 8'h80;
  localparam logic [7:0] PTR_LAST    = 8'hf7;
  localparam logic [7:0] PTR_INVALID = 8'hf8;
  localparam int         GLYPH_COUNT  = 24;
  localparam int         GLYPH_STRIDE = 5;
  localparam int         GLYPH_DEPTH  = GLYPH_COUNT * GLYPH_STRIDE;
  localparam logic [7:0] GLYPH_LAST_BASE = 8'hf3;
  // scan timing, counted in multiplex clock cycles
  localparam int ROW_TIME_US   = 100;
  localparam int REF_MUX_MHZ   = 4;
  localparam int SLOT_CYCLES   = ROW_TIME_US * REF_MUX_MHZ;
  localparam int PWM_STEPS     = 16;
  localparam int STEP_CYCLES   = SLOT_CYCLES / PWM_STEPS;
  localparam int ROWS          = 7;
  localparam int SCAN_SLOTS    = 2 * ROWS;
  localparam int SCAN_CYCLES   = 5600;
  localparam logic [4:0] STEP_CYCLES_LAST = 5'(STEP_CYCLES - 1);
  localparam logic [3:0] STEP_LAST        = 4'(PWM_STEPS - 1);
  localparam logic [3:0] SLOT_LAST_PAIR0  = 4'(ROWS - 1);
  localparam logic [3:0] SLOT_LAST_PAIR1  = 4'(SCAN_SLOTS - 1);
  localparam int BLINK_HALF_DEFAULT = 2000000;

  // drive pattern for the matrix
  typedef struct packed {
    logic [6:0] rowSel;
    logic [3:0] digitOn;
  } scan_drive_t;

  // one completed bus access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic [7:0] data;
  } bus_access_t;
endpackage

// ### design/glyph_pointer.sv
// autoincrementing pointer into the user glyph store
`timescale 1ns/1ps
`default_nettype none
module glyph_pointer (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       wrDone,
  input  wire logic       rdDone,
  input  wire logic [7:0] wrData,
  output logic [6:0]      rdData
);
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [6:0] store [matrix_scan_pkg::GLYPH_DEPTH]; // RULE4
  logic [6:0] idx;
  logic       access;

  // entry index relative to the first glyph slot
  assign idx    = 7'(ptr_reg - matrix_scan_pkg::PTR_FIRST);
  assign access = rdDone || (wrDone && !wrData[7]);
  assign rdData = store[idx];

  // pointer load, substitution and advance
  always_comb begin
    ptr_next = ptr_reg;
    if (wrDone && wrData[7]) begin
      if (wrData >= matrix_scan_pkg::PTR_INVALID) begin
        ptr_next = matrix_scan_pkg::PTR_FIRST; // RULE3
      end else begin
        ptr_next = wrData; // RULE18
      end
    end else if (access) begin
      if (ptr_reg == matrix_scan_pkg::PTR_LAST) begin
        ptr_next = matrix_scan_pkg::PTR_FIRST; // RULE2
      end else begin
        ptr_next = ptr_reg + 8'h01; // RULE1
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_reg <= matrix_scan_pkg::PTR_FIRST;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // seven data bits stored at the pointer
  always_ff @(posedge core_clk) begin
    if (wrDone && !wrData[7]) begin
      store[idx] <= wrData[6:0]; // RULE18
    end
  end

  property p_bad_load;
    @(posedge core_clk) disable iff (rst)
    wrDone && wrData >= 8'hf8 |=> ptr_reg == 8'h80;
  endproperty
  a_bad_load: assert property (p_bad_load) else $error("bad pointer not replaced"); // RULE3

  property p_wrap;
    @(posedge core_clk) disable iff (rst)
    (rdDone || (wrDone && !wrData[7])) && ptr_reg == 8'hf7 |=> ptr_reg == 8'h80;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // RULE2

  property p_advance;
    @(posedge core_clk) disable iff (rst)
    (rdDone || (wrDone && !wrData[7])) && ptr_reg < 8'hf7 |=> ptr_reg == $past(ptr_reg) + 8'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("pointer did not advance"); // RULE1

  property p_in_range;
    @(posedge core_clk) disable iff (rst)
    ptr_reg >= 8'h80 && ptr_reg <= 8'hf7;
  endproperty
  a_in_range: assert property (p_in_range) else $error("pointer out of range"); // RULE4
endmodule // glyph_pointer
`default_nettype wire

// ### design/matrix_scan_and_font_pointer.sv
// multiplex scan, brightness, blink and glyph pointer control with an apb slave
// How it works
// RULE1: pointer loads 0x80..0xF7 are legal; each glyph access advances it by one.
// RULE2: an access at pointer 0xF7 sends the pointer back to 0x80.
// RULE3: loading 0xF8..0xFF puts 0x80 in the pointer instead.
// RULE4: 24 glyphs of five entries each, glyph n based at 0x80 plus 5n.
// RULE5: the multiplex clock pin paces both the scan and the blink.
// RULE6: a full four-digit scan lasts 5600 multiplex clock cycles.
// RULE7: at a 4 MHz multiplex clock each row slot lasts 100 us.
// RULE8: the host may feed an exact 1 to 8 MHz clock to the pin.
// RULE9: setting the sync bit restarts blink timing and the scan sequence.
// RULE10: blink pin is high in the primary plane phase, low in alternate.
// RULE11: config reads return the blink phase, equal to the blink pin.
// RULE12: host may use blink edges to update the idle plane in time.
// RULE13: digits 0 and 1 share one slot, digits 2 and 3 the next.
// RULE14: scan limit clear scans only the first pair, set scans both.
// RULE15: four modulators, one per digit, each set by its own nibble.
// RULE16: duty from 1/16 to 15/16, step fifteen of each slot always blank.
// RULE17: writing the null register changes nothing.
// RULE18: glyph register loads the pointer, stores or returns seven data bits.
// RULE19: scan limit is bit zero of register 3, other bits ignored.
// RULE20: each row slot is 400 multiplex cycles, fourteen slots per scan.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module matrix_scan_and_font_pointer #(
  parameter int BLINK_HALF = matrix_scan_pkg::BLINK_HALF_DEFAULT
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic                              pready,
  output logic [31:0]                       prdata,
  output logic                              pslverr,
  input  wire logic                         mux_clock_pin,
  output logic                              blinkPin,
  output matrix_scan_pkg::scan_drive_t      scanDrive
);
  // bus side state
  matrix_scan_pkg::bus_access_t acc;
  logic [7:0]  brightLow_reg;
  logic [7:0]  brightHigh_reg;
  logic        scanLimit_reg;
  logic        mapped;
  logic        done;
  logic        syncStrobe;
  logic [6:0]  glyphData;
  logic [7:0]  readValue;
  // link side state
  logic        muxMeta;
  logic        muxSync;
  logic        muxSyncD;
  logic        muxTick;
  logic [4:0]  subCnt_reg;
  logic [3:0]  step_reg;
  logic [3:0]  slot_reg;
  logic [3:0]  slotLast;
  logic [31:0] blinkCnt_reg;
  logic        phase_reg;
  logic [15:0] nibbles;
  logic [3:0]  pwmOn;

  // decode of the completing access, word aligned
  assign done   = psel && penable && pready;
  assign acc    = {done && pwrite, done && !pwrite, paddr[9:2], pwdata[7:0]}; // one driver
  assign mapped = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'b00)
                  && (paddr[9:2] <= matrix_scan_pkg::IDX_GLYPH);
  assign syncStrobe = acc.wr && mapped && acc.idx == matrix_scan_pkg::IDX_CONFIG
                      && acc.data[matrix_scan_pkg::CFG_SYNC_BIT]; // RULE9

  // one wait state, then the answer with registered data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        prdata <= (mapped && !pwrite) ? {24'h000000, readValue} : 32'h00000000;
      end
    end
  end

  // read multiplexer
  always_comb begin
    case (paddr[9:2])
      matrix_scan_pkg::IDX_BRIGHT_LOW:  readValue = brightLow_reg;
      matrix_scan_pkg::IDX_BRIGHT_HIGH: readValue = brightHigh_reg;
      matrix_scan_pkg::IDX_SCAN_LIMIT:  readValue = {7'h00, scanLimit_reg};
      matrix_scan_pkg::IDX_CONFIG:      readValue = {phase_reg, 7'h00}; // RULE11
      matrix_scan_pkg::IDX_GLYPH:       readValue = {1'b0, glyphData}; // RULE18
      default:                          readValue = 8'h00; // RULE17
    endcase
  end

  // software settings; the null register has no storage at all
  always_ff @(posedge core_clk) begin
    if (rst) begin
      brightLow_reg  <= matrix_scan_pkg::BRIGHT_RESET;
      brightHigh_reg <= matrix_scan_pkg::BRIGHT_RESET;
      scanLimit_reg  <= matrix_scan_pkg::SCAN_LIMIT_RESET;
    end else if (acc.wr && mapped) begin
      case (acc.idx)
        matrix_scan_pkg::IDX_BRIGHT_LOW:  brightLow_reg  <= acc.data; // RULE15
        matrix_scan_pkg::IDX_BRIGHT_HIGH: brightHigh_reg <= acc.data; // RULE15
        matrix_scan_pkg::IDX_SCAN_LIMIT:
          scanLimit_reg <= acc.data[matrix_scan_pkg::SCAN_LIMIT_BIT]; // RULE19
        default: ; // RULE17
      endcase
    end
  end

  // glyph store and pointer
  glyph_pointer u_glyph (
    .core_clk (core_clk),
    .rst      (rst),
    .wrDone   (acc.wr && mapped && acc.idx == matrix_scan_pkg::IDX_GLYPH),
    .rdDone   (acc.rd && mapped && acc.idx == matrix_scan_pkg::IDX_GLYPH),
    .wrData   (acc.data),
    .rdData   (glyphData)
  );

  // two-stage synchroniser and rising edge of the multiplex clock pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      muxMeta  <= 1'b0;
      muxSync  <= 1'b0;
      muxSyncD <= 1'b0;
    end else begin
      muxMeta  <= mux_clock_pin;
      muxSync  <= muxMeta;
      muxSyncD <= muxSync;
    end
  end
  assign muxTick = muxSync && !muxSyncD; // RULE5

  // last slot of the scan depends on the scan limit
  assign slotLast = scanLimit_reg ? matrix_scan_pkg::SLOT_LAST_PAIR1
                                  : matrix_scan_pkg::SLOT_LAST_PAIR0; // RULE14

  // slot timing: 16 steps of 25 ticks make a 400 tick row slot
  always_ff @(posedge core_clk) begin
    if (rst || syncStrobe) begin // RULE9
      subCnt_reg <= 5'h00;
      step_reg   <= 4'h0;
      slot_reg   <= 4'h0;
    end else if (muxTick) begin
      if (subCnt_reg == matrix_scan_pkg::STEP_CYCLES_LAST) begin
        subCnt_reg <= 5'h00;
        step_reg   <= step_reg + 4'h1; // RULE20
        if (step_reg == matrix_scan_pkg::STEP_LAST) begin
          slot_reg <= (slot_reg >= slotLast) ? 4'h0 : slot_reg + 4'h1; // RULE6
        end
      end else begin
        subCnt_reg <= subCnt_reg + 5'h01; // RULE7
      end
    end
  end

  // per digit modulators; step fifteen is always blank
  assign nibbles = {brightHigh_reg, brightLow_reg};
  genvar d;
  generate
    for (d = 0; d < 4; d++) begin : g_pwm
      assign pwmOn[d] = (step_reg <= nibbles[4*d +: 4])
                        && (step_reg != matrix_scan_pkg::STEP_LAST); // RULE16
    end
  endgenerate

  // registered row and digit drive
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scanDrive <= '0;
    end else if (slot_reg < 4'(matrix_scan_pkg::ROWS)) begin
      scanDrive.rowSel  <= 7'(7'h01 << slot_reg);
      scanDrive.digitOn <= {2'b00, pwmOn[1:0]}; // RULE13
    end else begin
      scanDrive.rowSel  <= 7'(7'h01 << (slot_reg - 4'(matrix_scan_pkg::ROWS)));
      scanDrive.digitOn <= {pwmOn[3:2], 2'b00}; // RULE13
    end
  end

  // blink phase from multiplex ticks
  always_ff @(posedge core_clk) begin
    if (rst || syncStrobe) begin // RULE9
      blinkCnt_reg <= 32'h00000000;
      phase_reg    <= matrix_scan_pkg::PHASE_RESET;
    end else if (muxTick) begin
      if (blinkCnt_reg == 32'(BLINK_HALF - 1)) begin
        blinkCnt_reg <= 32'h00000000;
        phase_reg    <= !phase_reg; // RULE5
      end else begin
        blinkCnt_reg <= blinkCnt_reg + 32'h00000001;
      end
    end
  end
  assign blinkPin = phase_reg; // RULE10

  // phase readback carries the pin level of the latching cycle
  property p_pin_phase;
    @(posedge core_clk) disable iff (rst)
    acc.rd && mapped && acc.idx == 8'h04 |-> prdata[7] == $past(blinkPin);
  endproperty
  a_pin_phase: assert property (p_pin_phase) else $error("phase readback differs from pin"); // RULE11

  // sync restarts the scan and the blink phase
  property p_sync;
    @(posedge core_clk) disable iff (rst)
    syncStrobe |=> phase_reg && slot_reg == 4'h0 && step_reg == 4'h0 && blinkCnt_reg == 32'h0;
  endproperty
  a_sync: assert property (p_sync) else $error("sync did not restart timing"); // RULE9

  // limit clear keeps the scan in the first pair
  property p_limit;
    @(posedge core_clk) disable iff (rst)
    !scanLimit_reg && $past(!scanLimit_reg) && $past(slot_reg) < 4'h7 |-> slot_reg < 4'h7;
  endproperty
  a_limit: assert property (p_limit) else $error("second pair scanned with limit clear"); // RULE14

  // step fifteen blanks every digit
  property p_blank;
    @(posedge core_clk) disable iff (rst)
    step_reg == 4'hf |=> scanDrive.digitOn == 4'h0;
  endproperty
  a_blank: assert property (p_blank) else $error("digit lit in blank step"); // RULE16

  // the two digit pairs never share a slot
  property p_pair;
    @(posedge core_clk) disable iff (rst)
    scanDrive.digitOn[1:0] == 2'b00 || scanDrive.digitOn[3:2] == 2'b00;
  endproperty
  a_pair: assert property (p_pair) else $error("both digit pairs driven together"); // RULE13

  // null writes leave all settings alone
  property p_null;
    @(posedge core_clk) disable iff (rst)
    acc.wr && paddr == 32'h0 |=> $stable(brightLow_reg) && $stable(brightHigh_reg)
      && $stable(scanLimit_reg);
  endproperty
  a_null: assert property (p_null) else $error("null write changed state"); // RULE17

  // sixteen steps of 25 ticks close a slot
  property p_slot_len;
    @(posedge core_clk) disable iff (rst)
    muxTick && !syncStrobe && subCnt_reg == 5'h18 && step_reg == 4'hf |=> subCnt_reg == 5'h00
      && step_reg == 4'h0;
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot did not end after 400 ticks"); // RULE20

  // scan limit takes bit zero only
  property p_scan_limit_bit;
    @(posedge core_clk) disable iff (rst)
    acc.wr && paddr == 32'hc |=> scanLimit_reg == $past(pwdata[0]);
  endproperty
  a_scan_limit_bit: assert property (p_scan_limit_bit) else $error("scan limit not bit zero"); // RULE19

  // at most one row driven at a time
  property p_row_onehot;
    @(posedge core_clk) disable iff (rst)
    $onehot0(scanDrive.rowSel);
  endproperty
  a_row_onehot: assert property (p_row_onehot) else $error("more than one row driven"); // RULE13

  // slot counter stays inside fourteen slots
  property p_slot_range;
    @(posedge core_clk) disable iff (rst)
    slot_reg <= matrix_scan_pkg::SLOT_LAST_PAIR1;
  endproperty
  a_slot_range: assert property (p_slot_range) else $error("slot beyond the last row"); // RULE20

  // tick counter stays inside one modulation step
  property p_sub_range;
    @(posedge core_clk) disable iff (rst)
    subCnt_reg <= matrix_scan_pkg::STEP_CYCLES_LAST;
  endproperty
  a_sub_range: assert property (p_sub_range) else $error("step longer than 25 ticks"); // RULE7

  // scan counters move only on a multiplex tick or a sync
  property p_tick_pace;
    @(posedge core_clk) disable iff (rst)
    !muxTick && !syncStrobe |=> $stable(subCnt_reg) && $stable(step_reg) && $stable(slot_reg);
  endproperty
  a_tick_pace: assert property (p_tick_pace) else $error("scan moved without a tick"); // RULE5

  // phase moves only after a full half period, a sync or a reset
  property p_blink_toggle;
    @(posedge core_clk) disable iff (rst)
    $changed(phase_reg) |-> $past(rst) || $past(syncStrobe)
      || ($past(muxTick) && $past(blinkCnt_reg) == 32'(BLINK_HALF - 1));
  endproperty
  a_blink_toggle: assert property (p_blink_toggle) else $error("blink phase moved early"); // RULE5

  // digit zero lights only in its pair's slots and within its nibble
  property p_dim;
    @(posedge core_clk) disable iff (rst)
    scanDrive.digitOn[0] |-> $past(slot_reg) < 4'h7
      && $past(step_reg) <= $past(brightLow_reg[3:0]);
  endproperty
  a_dim: assert property (p_dim) else $error("digit zero lit outside its duty"); // RULE15

  // glyph reads return seven bits with the top bits clear
  property p_glyph_read;
    @(posedge core_clk) disable iff (rst)
    acc.rd && mapped && acc.idx == matrix_scan_pkg::IDX_GLYPH |-> prdata[31:7] == '0;
  endproperty
  a_glyph_read: assert property (p_glyph_read) else $error("glyph read wider than seven bits"); // RULE18

  // a four digit scan wraps from slot thirteen back to slot zero
  property p_scan_wrap;
    @(posedge core_clk) disable iff (rst)
    muxTick && !syncStrobe && scanLimit_reg && slot_reg == matrix_scan_pkg::SLOT_LAST_PAIR1
      && step_reg == matrix_scan_pkg::STEP_LAST
      && subCnt_reg == matrix_scan_pkg::STEP_CYCLES_LAST |=> slot_reg == 4'h0;
  endproperty
  a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap"); // RULE6
endmodule // matrix_scan_and_font_pointer
`default_nettype wire

// ### dv/mux_clock_src.sv
// external multiplex clock source for the oscillator pin
`timescale 1ns/1ps
`default_nettype none
module mux_clock_src #(
  parameter int PERIOD_NS = 32
) (
  output logic muxClk
);
  // free-running clock with a phase unrelated to the core clock
  initial begin
    muxClk = 1'b0;
    #3;
    forever #(PERIOD_NS / 2) muxClk = ~muxClk;
  end
endmodule // mux_clock_src
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the matrix scan and glyph pointer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int HALF = 16;
  logic                         core_clk;
  logic                         rst;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [31:0]                  paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic [31:0]                  rdv;
  logic                         pready;
  logic                         pslverr;
  logic                         errv;
  logic                         muxPin;
  logic                         blinkPin;
  matrix_scan_pkg::scan_drive_t scanDrive;
  logic [6:0]                   gd [0:5];
  logic [15:0]                  br;
  logic [7:0]                   n8;
  int                           cnt [0:4];
  int                           w;
  int                           error_cnt = 0;
  int                           total_checks = 0;
  integer                       seed = 32'h59aa;
  time                          t0;

  matrix_scan_and_font_pointer #(.BLINK_HALF(HALF)) matrix_scan_and_font_pointer_i (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mux_clock_pin(muxPin), .blinkPin(blinkPin), .scanDrive(scanDrive)
  );
  mux_clock_src #(.PERIOD_NS(32)) mux_clock_src_i (.muxClk(muxPin));

  // core clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 16) error_cnt++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // count lit cycles per digit and cycles with both pairs lit
  task automatic mon(input int cyc);
    for (int i = 0; i < 5; i++) cnt[i] = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      for (int d = 0; d < 4; d++) cnt[d] += int'(scanDrive.digitOn[d]);
      cnt[4] += int'((|scanDrive.digitOn[1:0]) & (|scanDrive.digitOn[3:2]));
    end
  endtask

  // lit core cycles: steps 0..nibble, step fifteen always blank
  function automatic int lit(input logic [3:0] nib, input int slots);
    int s;
    s = (nib == 4'hf) ? 14 : int'(nib);
    return slots * (s + 1) * 25 * 8;
  endfunction

  task automatic duty(input int s01, input int s23);
    int e;
    for (int d = 0; d < 4; d++) begin
      e = lit(br[4*d +: 4], d < 2 ? s01 : s23);
      chk(32'(cnt[d] > e - 64 && cnt[d] < e + 64), 32'h1);
    end
    chk(32'(cnt[4]), 32'h0);
  endtask

  task automatic waitPin(input logic v);
    w = 0;
    while (blinkPin !== v && w < 4000) begin
      w++;
      @(posedge core_clk);
    end
    if (w == 4000) error_cnt++;
  endtask

  task automatic waitRow();
    logic [6:0] r;
    r = scanDrive.rowSel;
    w = 0;
    while (scanDrive.rowSel === r && w < 5000) begin
      w++;
      @(posedge core_clk);
    end
    if (w == 5000) error_cnt++;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, matrix_scan_pkg::IDX_CONFIG, 8'h00);
    chk(32'(rdv[7]), 32'(matrix_scan_pkg::PHASE_RESET));
    chk(32'(blinkPin), 32'h1);
    apb(1'b1, matrix_scan_pkg::IDX_GLYPH, matrix_scan_pkg::GLYPH_LAST_BASE);
    for (int i = 0; i < 6; i++) begin
      gd[i] = 7'($random(seed));
      apb(1'b1, matrix_scan_pkg::IDX_GLYPH, {1'b0, gd[i]});
    end
    apb(1'b1, matrix_scan_pkg::IDX_GLYPH, matrix_scan_pkg::GLYPH_LAST_BASE);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, matrix_scan_pkg::IDX_GLYPH, 8'h00);
      chk(rdv, {25'h0, gd[i]});
    end
    apb(1'b1, matrix_scan_pkg::IDX_GLYPH, 8'hf8 | 8'($random(seed)));
    apb(1'b0, matrix_scan_pkg::IDX_GLYPH, 8'h00);
    chk(rdv, {25'h0, gd[5]});
    n8 = 8'h80 + 8'(5 * (1 + ($unsigned($random(seed)) % 22)));
    apb(1'b1, matrix_scan_pkg::IDX_GLYPH, n8);
    apb(1'b1, matrix_scan_pkg::IDX_GLYPH, 8'h2a);
    apb(1'b1, matrix_scan_pkg::IDX_GLYPH, n8);
    apb(1'b0, matrix_scan_pkg::IDX_GLYPH, 8'h00);
    chk(rdv, 32'h2a);
    br = {8'($random(seed)) & 8'hf0, 8'($random(seed)) | 8'h0f};
    apb(1'b1, matrix_scan_pkg::IDX_BRIGHT_LOW, br[7:0]);
    apb(1'b1, matrix_scan_pkg::IDX_BRIGHT_HIGH, br[15:8]);
    apb(1'b1, matrix_scan_pkg::IDX_NULL, 8'hff);
    apb(1'b0, matrix_scan_pkg::IDX_BRIGHT_LOW, 8'h00);
    chk(rdv, {24'h0, br[7:0]});
    apb(1'b0, matrix_scan_pkg::IDX_BRIGHT_HIGH, 8'h00);
    chk(rdv, {24'h0, br[15:8]});
    apb(1'b0, 8'h06, 8'h00);
    chk({rdv[30:0], errv}, 32'h1);
    apb(1'b1, matrix_scan_pkg::IDX_SCAN_LIMIT, 8'hfe);
    apb(1'b0, matrix_scan_pkg::IDX_SCAN_LIMIT, 8'h00);
    chk(rdv, 32'h0);
    apb(1'b1, matrix_scan_pkg::IDX_CONFIG, 8'h10);
    mon(25600);
    duty(8, 0);
    apb(1'b1, matrix_scan_pkg::IDX_SCAN_LIMIT, 8'h01);
    apb(1'b1, matrix_scan_pkg::IDX_CONFIG, 8'h10);
    mon(25600);
    duty(7, 1);
    waitRow();
    t0 = $time;
    waitRow();
    chk(32'(($time - t0 + 16) / 32), 32'd400);
    chk(32'($countones(scanDrive.rowSel)), 32'h1);
    waitPin(1'b0);
    apb(1'b1, matrix_scan_pkg::IDX_CONFIG, 8'h10);
    @(posedge core_clk);
    chk(32'(blinkPin), 32'h1);
    waitPin(1'b0);
    chk(32'(w > 8 * HALF - 9 && w <= 8 * HALF), 32'h1);
    apb(1'b0, matrix_scan_pkg::IDX_CONFIG, 8'h00);
    chk(32'(rdv[7]), 32'(blinkPin));
    waitPin(1'b1);
    apb(1'b1, matrix_scan_pkg::IDX_BRIGHT_HIGH, br[7:0]);
    chk(32'(blinkPin), 32'h1);
    apb(1'b0, matrix_scan_pkg::IDX_BRIGHT_HIGH, 8'h00);
    chk(rdv, {24'h0, br[7:0]});
    end_sim();
  end

  // watchdog against a hung run
  initial begin
    #320000;
    error_cnt++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
